// *** design/fps_defines.svh ***
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// system clock
`define FPS_CLK_MHZ          50
// blanking after gate turn-on, ns
`define FPS_LEB_NS           350
`define FPS_LEB_CYC          ((`FPS_LEB_NS * `FPS_CLK_MHZ + 999) / 1000)
// aux sample delay after turn-off, ns
`define FPS_AUX_DLY_NS       2000
`define FPS_AUX_DLY_CYC      ((`FPS_AUX_DLY_NS * `FPS_CLK_MHZ + 999) / 1000)
// short protection debounce, ms
`define FPS_SHORT_MS         16
`define FPS_SHORT_CYC        (`FPS_SHORT_MS * 1000 * `FPS_CLK_MHZ)
// overload debounce in timer-capacitor ticks
`define FPS_OLP_TICKS        16'h0400
// aux over-voltage cycles before trip
`define FPS_AUX_OV_CNT       3'h4
// supply turn-off crossings before overload release
`define FPS_OLP_RELEASE_CNT  3'h4
// fault-hiccup on-window after supply turn-on, cycles
`define FPS_HICCUP_CYC       16'h0100
// timer counter widths
`define FPS_CNT_W            24

`endif

// *** design/fps_pkg.sv ***
package fps_pkg;
   typedef enum logic [1:0] {
      FPS_ST_OFF  = 2'b00,
      FPS_ST_WAIT = 2'b01,
      FPS_ST_ON   = 2'b10
   } fps_gate_e;
endpackage

// *** design/fps_sequencer.sv ***
// Contract
// - end on-time when current reaches feedback/5.5
// - burst stop disables, start re-enables gate
// - cycle limit at fixed maximum current
// - compensation only high line, feedback high
// - blank current compare after gate turn-on
// - fault hiccup at supply turn-on, auto-recover
// - overload after delay stops gate
// - overload releases on fourth supply turn-off
// - short protection: feedback high, low supply
// - supply over-voltage off until next turn-on
// - turn on at aux falling edge
// - sample aux over-voltage after turn-off delay
// - flag aux over-voltage per cycle
// - trip after four successive aux events
// - chip over-temperature disables until cleared
// - external over-temperature stops switching
// - protection off removes temperature bias
// - line hysteresis selects compensation enable
// - one capacitor timer scales debounce times (here only the overload debounce; the short debounce counts the clock)
// - supply on/off thresholds gate operation
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"

module fps_sequencer
   import fps_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // feedback comparators
   input  wire logic fb_above_sense_in,
   input  wire logic fb_below_stop_in,
   input  wire logic fb_above_start_in,
   input  wire logic fb_above_olp_in,
   input  wire logic fb_above_comp_in,
   // current and aux comparators
   input  wire logic sense_above_max_in,
   input  wire logic aux_above_trigger_in,
   input  wire logic aux_above_ov_in,
   // supply and line comparators
   input  wire logic supply_above_on_in,
   input  wire logic supply_below_off_in,
   input  wire logic supply_below_short_in,
   input  wire logic supply_over_in,
   input  wire logic line_above_high_in,
   input  wire logic line_below_low_in,
   // temperature and timer
   input  wire logic chip_hot_in,
   input  wire logic ext_hot_in,
   input  wire logic timer_tick_in,
   // outputs
   output logic      flyback_gate_out,
   output logic      comp_offset_en_out,
   output logic      temp_bias_en_out,
   output logic      fault_active_out
);
   fps_gate_e state_ff;
   fps_gate_e nxt_state;
   logic      burst_off_ff;
   logic      high_line_ff;
   logic      aux_prev_ff;
   logic      supply_on_prev_ff;
   logic      supply_off_prev_ff;
   logic      ok_ff;
   logic      olp_ff;
   logic      short_ff;
   logic      vov_ff;
   logic      auxov_ff;
   logic      chip_hot_ff;
   logic [2:0] olp_cnt_ff;
   logic [2:0] auxov_cnt_ff;
   logic [15:0] leb_cnt_ff;
   logic [15:0] aux_dly_cnt_ff;
   logic [15:0] hiccup_cnt_ff;
   logic      aux_sampled_ff;
   logic      olp_done;
   logic      short_done;
   logic      aux_fall;
   logic      supply_on_rise;
   logic      supply_off_rise;
   logic      latched_fault;
   logic      hard_off;
   logic      end_on;
   logic      aux_trip;
   logic      fault_set;

   assign aux_fall        = aux_prev_ff && !aux_above_trigger_in;
   assign supply_on_rise  = supply_above_on_in && !supply_on_prev_ff;
   assign supply_off_rise = supply_below_off_in && !supply_off_prev_ff;
   assign latched_fault   = olp_ff || short_ff || vov_ff || auxov_ff;

   // any condition wins over the switching request
   assign hard_off = !ok_ff || burst_off_ff || chip_hot_ff || ext_hot_in
                     || fb_below_stop_in || olp_ff || supply_over_in
                     || (latched_fault && hiccup_cnt_ff == 16'h0000);

   // blanking masks the current comparators right after turn-on
   assign end_on = (leb_cnt_ff == 16'h0000)
                   && (fb_above_sense_in || sense_above_max_in);

   // fourth successive over-voltage sample closes the latch
   assign aux_trip  = aux_sampled_ff && aux_above_ov_in
                      && (auxov_cnt_ff + 3'h1 >= `FPS_AUX_OV_CNT);

   // a new short, supply over-voltage or aux latch ends any open hiccup window unless a supply turn-on reloads it that cycle: off until the next turn-on
   assign fault_set = supply_over_in || aux_trip
                      || (short_done && supply_below_short_in);

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aux_prev_ff        <= 1'b0;
         supply_on_prev_ff  <= 1'b0;
         supply_off_prev_ff <= 1'b0;
      end else begin
         aux_prev_ff        <= aux_above_trigger_in;
         supply_on_prev_ff  <= supply_above_on_in;
         supply_off_prev_ff <= supply_below_off_in;
      end
   end

   // supply lockout with hysteresis
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ok_ff <= 1'b0;
      end else if (supply_below_off_in) begin
         ok_ff <= 1'b0;
      end else if (supply_above_on_in) begin
         ok_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         burst_off_ff <= 1'b0;
      end else if (fb_below_stop_in) begin
         burst_off_ff <= 1'b1;
      end else if (fb_above_start_in) begin
         burst_off_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         high_line_ff <= 1'b0;
      end else if (line_above_high_in) begin
         high_line_ff <= 1'b1;
      end else if (line_below_low_in) begin
         high_line_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chip_hot_ff <= 1'b0;
      end else begin
         chip_hot_ff <= chip_hot_in;
      end
   end

   // overload debounce counts the capacitor timer, short debounce the clock
   fps_timer u_olp_timer (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .run_in   (fb_above_olp_in && !olp_ff),
      .tick_in  (timer_tick_in),
      .limit_in (`FPS_CNT_W'(`FPS_OLP_TICKS)),
      .done_out (olp_done)
   );

   fps_timer u_short_timer (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .run_in   (fb_above_olp_in && !short_ff),
      .tick_in  (1'b1),
      .limit_in (`FPS_CNT_W'(`FPS_SHORT_CYC)),
      .done_out (short_done)
   );

   // overload holds until the fourth supply turn-off crossing
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         olp_ff     <= 1'b0;
         olp_cnt_ff <= 3'h0;
      end else if (!olp_ff) begin
         olp_cnt_ff <= 3'h0;
         if (olp_done) begin
            olp_ff <= 1'b1;
         end
      end else if (supply_off_rise) begin
         if (olp_cnt_ff + 3'h1 == `FPS_OLP_RELEASE_CNT) begin
            olp_ff     <= 1'b0;
            olp_cnt_ff <= 3'h0;
         end else begin
            olp_cnt_ff <= olp_cnt_ff + 3'h1;
         end
      end
   end

   // short, supply over-voltage: cleared at next supply turn-on if gone
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         short_ff <= 1'b0;
      end else if (short_done && supply_below_short_in) begin
         short_ff <= 1'b1;
      end else if (supply_on_rise && !fb_above_olp_in) begin
         short_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         vov_ff <= 1'b0;
      end else if (supply_over_in) begin
         vov_ff <= 1'b1;
      end else if (supply_on_rise) begin
         vov_ff <= 1'b0;
      end
   end

   // hiccup window: a brief switching burst after each supply turn-on
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hiccup_cnt_ff <= 16'h0000;
      end else if (supply_on_rise) begin
         hiccup_cnt_ff <= `FPS_HICCUP_CYC;
      end else if (fault_set) begin
         hiccup_cnt_ff <= 16'h0000;
      end else if (hiccup_cnt_ff != 16'h0000) begin
         hiccup_cnt_ff <= hiccup_cnt_ff - 16'h0001;
      end
   end

   // gate sequencing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FPS_ST_OFF: begin
            if (!hard_off) begin
               nxt_state = FPS_ST_WAIT;
            end
         end
         FPS_ST_WAIT: begin
            if (hard_off) begin
               nxt_state = FPS_ST_OFF;
            end else if (aux_fall) begin
               nxt_state = FPS_ST_ON;
            end
         end
         FPS_ST_ON: begin
            if (hard_off || end_on) begin
               nxt_state = FPS_ST_WAIT;
            end
         end
         default: begin
            nxt_state = FPS_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= FPS_ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flyback_gate_out <= 1'b0;
      end else begin
         flyback_gate_out <= (nxt_state == FPS_ST_ON);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         leb_cnt_ff <= 16'h0000;
      end else if (state_ff != FPS_ST_ON && nxt_state == FPS_ST_ON) begin
         leb_cnt_ff <= 16'(`FPS_LEB_CYC);
      end else if (leb_cnt_ff != 16'h0000) begin
         leb_cnt_ff <= leb_cnt_ff - 16'h0001;
      end
   end

   // aux sample after turn-off delay, ringing ignored meanwhile
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aux_dly_cnt_ff <= 16'h0000;
         aux_sampled_ff <= 1'b0;
      end else if (state_ff == FPS_ST_ON && nxt_state != FPS_ST_ON) begin
         aux_dly_cnt_ff <= 16'(`FPS_AUX_DLY_CYC);
         aux_sampled_ff <= 1'b0;
      end else if (aux_dly_cnt_ff != 16'h0000) begin
         aux_dly_cnt_ff <= aux_dly_cnt_ff - 16'h0001;
         aux_sampled_ff <= (aux_dly_cnt_ff == 16'h0001);
      end else begin
         aux_sampled_ff <= 1'b0;
      end
   end

   // successive over-voltage samples; a clean sample restarts the count
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         auxov_cnt_ff <= 3'h0;
      end else if (aux_sampled_ff) begin
         if (aux_trip) begin
            auxov_cnt_ff <= 3'h0;
         end else if (aux_above_ov_in) begin
            auxov_cnt_ff <= auxov_cnt_ff + 3'h1;
         end else begin
            auxov_cnt_ff <= 3'h0;
         end
      end
   end

   // trip wins over a turn-on clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         auxov_ff <= 1'b0;
      end else if (aux_trip) begin
         auxov_ff <= 1'b1;
      end else if (supply_on_rise) begin
         auxov_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         comp_offset_en_out <= 1'b0;
         temp_bias_en_out   <= 1'b0;
         fault_active_out   <= 1'b0;
      end else begin
         comp_offset_en_out <= high_line_ff && fb_above_comp_in;
         temp_bias_en_out   <= !(latched_fault || chip_hot_ff || ext_hot_in);
         fault_active_out   <= latched_fault || chip_hot_ff || ext_hot_in;
      end
   end
endmodule // fps_sequencer

`default_nettype wire

// *** design/fps_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"

// counts tick_in pulses while run is high; done after limit counts
module fps_timer (
   // clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 rst_n_in,
   // control
   input  wire logic                 run_in,
   input  wire logic                 tick_in,
   input  wire logic [`FPS_CNT_W-1:0] limit_in,
   // status
   output logic                      done_out
);
   logic [`FPS_CNT_W-1:0] count_ff;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_ff <= '0;
      end else if (!run_in) begin
         count_ff <= '0;
      end else if (tick_in && count_ff != limit_in) begin
         count_ff <= count_ff + 1'b1;
      end
   end

   assign done_out = run_in && (count_ff == limit_in);
endmodule // fps_timer

`default_nettype wire

// *** testbench/fps_sequencer_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module fps_sequencer_chk (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // comparator flags
   input wire logic fb_above_sense_in,
   input wire logic fb_below_stop_in,
   input wire logic fb_above_start_in,
   input wire logic fb_above_olp_in,
   input wire logic fb_above_comp_in,
   input wire logic sense_above_max_in,
   input wire logic aux_above_trigger_in,
   input wire logic aux_above_ov_in,
   input wire logic supply_above_on_in,
   input wire logic supply_below_off_in,
   input wire logic supply_below_short_in,
   input wire logic supply_over_in,
   input wire logic line_above_high_in,
   input wire logic line_below_low_in,
   input wire logic chip_hot_in,
   input wire logic ext_hot_in,
   input wire logic timer_tick_in,
   // outputs
   input wire logic flyback_gate_out,
   input wire logic comp_offset_en_out,
   input wire logic temp_bias_en_out,
   input wire logic fault_active_out
);
   logic [4:0] on_cnt_ff;
   logic       hard_c;
   // overload and lockout trips may also land inside blanking
   assign hard_c = fb_below_stop_in | chip_hot_in | ext_hot_in | supply_over_in | fb_above_olp_in
                   | supply_below_off_in;
   // saturates so long on-times never wrap into the blanking range
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) on_cnt_ff <= 5'h00;
      else if (!flyback_gate_out) on_cnt_ff <= 5'h00;
      else if (on_cnt_ff != 5'h1F) on_cnt_ff <= on_cnt_ff + 5'h01;
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_BURST_OFF: assert property (fb_below_stop_in |-> ##[1:2] !flyback_gate_out)
      else $error("gate high during burst stop");
   AST_CHIP_HOT: assert property (chip_hot_in |-> ##[1:2] !flyback_gate_out)
      else $error("gate high while chip hot");
   AST_EXT_HOT: assert property (ext_hot_in |-> ##[1:2] !flyback_gate_out)
      else $error("gate high while external hot");
   AST_SUPPLY_OV: assert property (supply_over_in |-> ##[1:2] !flyback_gate_out)
      else $error("gate high during supply over-voltage");
   AST_BIAS_OFF: assert property ((chip_hot_in || ext_hot_in) |-> ##[1:2] !temp_bias_en_out)
      else $error("temperature bias left on");
   AST_BLANK: assert property ((flyback_gate_out && on_cnt_ff < 5'h10 && !hard_c && !$past(hard_c)
      && !fault_active_out) |=> flyback_gate_out)
      else $error("gate ended inside blanking");
   AST_LIMIT: assert property ((flyback_gate_out && on_cnt_ff >= 5'h12 && sense_above_max_in)
      |-> ##[1:2] !flyback_gate_out)
      else $error("current limit ignored");
   AST_PEAK: assert property ((flyback_gate_out && on_cnt_ff >= 5'h12 && fb_above_sense_in)
      |-> ##[1:2] !flyback_gate_out)
      else $error("peak current end ignored");
   AST_VALLEY: assert property ($rose(flyback_gate_out) |-> !$past(aux_above_trigger_in))
      else $error("gate rose without aux fall");
   AST_COMP_OFF: assert property ((!fb_above_comp_in || line_below_low_in) |-> ##[1:2] !comp_offset_en_out)
      else $error("compensation on out of range");
   AST_COMP_ON: assert property ((line_above_high_in && fb_above_comp_in) |-> ##[1:2] comp_offset_en_out)
      else $error("compensation off at high line");
endmodule // fps_sequencer_chk
bind fps_sequencer fps_sequencer_chk i_fps_sequencer_chk (.*);
`default_nettype wire

// *** testbench/fps_stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fps_stage_model (
   // clock and reset
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   // gate and timing knobs
   input wire logic       gate_in,
   input wire logic [7:0] on_len_in,
   input wire logic [7:0] demag_len_in,
   // sensed levels
   output logic           aux_above_trigger_out,
   output logic           fb_above_sense_out
);
   logic [7:0] on_cnt_ff;
   logic [7:0] dem_cnt_ff;
   logic [7:0] idle_cnt_ff;
   logic       gate_d_ff;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         on_cnt_ff <= 8'h00;
         dem_cnt_ff <= 8'h00;
         idle_cnt_ff <= 8'h00;
         gate_d_ff <= 1'b0;
         aux_above_trigger_out <= 1'b0;
      end else begin
         gate_d_ff <= gate_in;
         on_cnt_ff <= gate_in ? on_cnt_ff + 8'h01 : 8'h00;
         // demagnetising after turn-off, then valley fall
         if (gate_d_ff && !gate_in) begin
            aux_above_trigger_out <= 1'b1;
            dem_cnt_ff <= demag_len_in;
            idle_cnt_ff <= 8'h00;
         end else if (aux_above_trigger_out) begin
            if (dem_cnt_ff == 8'h00) aux_above_trigger_out <= 1'b0;
            else dem_cnt_ff <= dem_cnt_ff - 8'h01;
         end else if (!gate_in) begin
            // ringing while idle, else a stopped stage never restarts
            idle_cnt_ff <= idle_cnt_ff + 8'h01;
            if (idle_cnt_ff == 8'h28) begin
               aux_above_trigger_out <= 1'b1;
               dem_cnt_ff <= demag_len_in;
               idle_cnt_ff <= 8'h00;
            end
         end
      end
   end
   assign fb_above_sense_out = gate_in && (on_cnt_ff >= on_len_in);
endmodule // fps_stage_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_in, rst_n_in, fb_above_sense_in, fb_below_stop_in, fb_above_start_in, fb_above_olp_in;
   logic fb_above_comp_in, sense_above_max_in, aux_above_trigger_in, aux_above_ov_in, supply_above_on_in;
   logic supply_below_off_in, supply_below_short_in, supply_over_in, line_above_high_in, line_below_low_in;
   logic chip_hot_in, ext_hot_in, timer_tick_in;
   logic flyback_gate_out, comp_offset_en_out, temp_bias_en_out, fault_active_out;
   logic [7:0] on_len, demag_len;
   logic [2:0] comp_rows [0:5] = '{3'b101, 3'b100, 3'b101, 3'b001, 3'b011, 3'b001};
   int err_count = 0, comparisons = 0, cycles = 0;
   fps_sequencer i_fps_sequencer (.*);
   fps_stage_model i_fps_stage_model (.clk_in(clk_in), .rst_n_in(rst_n_in), .gate_in(flyback_gate_out),
      .on_len_in(on_len), .demag_len_in(demag_len), .aux_above_trigger_out(aux_above_trigger_in),
      .fb_above_sense_out(fb_above_sense_in));
   always #10 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic check(input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_gate(input logic v);
      int k;
      k = 0;
      while (flyback_gate_out !== v && k < 400) begin
         step(1);
         k++;
      end
   endtask
   task automatic power_on();
      supply_above_on_in = 1'b1;
      step(1);
      supply_above_on_in = 1'b0;
   endtask
   task automatic t_comp();
      int i;
      for (i = 0; i < 6; i++) begin
         {line_above_high_in, line_below_low_in, fb_above_comp_in} = comp_rows[i];
         step(3);
         check(comp_offset_en_out, 1'(6'b001101 >> i));
      end
      $display("test comp done");
   endtask
   task automatic t_switch();
      int i;
      power_on();
      for (i = 0; i < 3; i++) begin
         wait_gate(1'b1);
         check(flyback_gate_out, 1'b1);
         wait_gate(1'b0);
         check(flyback_gate_out, 1'b0);
      end
      $display("test switch done");
   endtask
   task automatic t_blank();
      int n;
      on_len = 8'hC8;
      wait_gate(1'b1);
      sense_above_max_in = 1'b1;
      n = 0;
      while (flyback_gate_out === 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      check(n >= 17, 1'b1);
      check(n <= 20, 1'b1);
      sense_above_max_in = 1'b0;
      on_len = 8'h1E;
      $display("test blank done");
   endtask
   task automatic t_hard();
      int i;
      demag_len = 8'h03;
      for (i = 0; i < 4; i++) begin
         wait_gate(1'b1);
         {fb_below_stop_in, chip_hot_in, ext_hot_in, supply_over_in} = 4'h8 >> i;
         fb_above_start_in = (i != 0);
         step(3);
         check(flyback_gate_out, 1'b0);
         if (i == 1 || i == 2) check(temp_bias_en_out, 1'b0);
         {fb_below_stop_in, chip_hot_in, ext_hot_in, supply_over_in} = 4'h0;
         if (i == 0 || i == 3) begin
            step(60);
            check(flyback_gate_out, 1'b0);
         end
         if (i == 3) check(fault_active_out, 1'b1);
         fb_above_start_in = 1'b1;
         step(2);
         power_on();
         wait_gate(1'b1);
         check(flyback_gate_out, 1'b1);
         check(fault_active_out, 1'b0);
      end
      $display("test hard-off done");
   endtask
   task automatic t_olp();
      int i;
      fb_above_olp_in = 1'b1;
      step(1000);
      check(fault_active_out, 1'b0);
      step(30);
      check(fault_active_out, 1'b1);
      check(flyback_gate_out, 1'b0);
      check(temp_bias_en_out, 1'b0);
      fb_above_olp_in = 1'b0;
      for (i = 0; i < 4; i++) begin
         check(fault_active_out, 1'b1);
         supply_below_off_in = 1'b1;
         step(1);
         supply_below_off_in = 1'b0;
         step(1);
      end
      check(fault_active_out, 1'b0);
      check(temp_bias_en_out, 1'b1);
      power_on();
      wait_gate(1'b1);
      check(flyback_gate_out, 1'b1);
      $display("test overload done");
   endtask
   task automatic t_auxov();
      int i;
      demag_len = 8'h80;
      aux_above_ov_in = 1'b1;
      for (i = 0; i < 4; i++) begin
         wait_gate(1'b1);
         wait_gate(1'b0);
         step(95);
         check(fault_active_out, 1'b0);
         step(10);
         check(fault_active_out, i == 3);
      end
      step(200);
      check(flyback_gate_out, 1'b0);
      aux_above_ov_in = 1'b0;
      demag_len = 8'h03;
      power_on();
      wait_gate(1'b1);
      check(fault_active_out, 1'b0);
      $display("test aux over-voltage done");
   endtask
   initial begin
      clk_in = 1'b0;
      rst_n_in = 1'b0;
      {fb_below_stop_in, fb_above_olp_in, fb_above_comp_in, sense_above_max_in, aux_above_ov_in} = 5'h00;
      {supply_above_on_in, supply_below_off_in, supply_below_short_in, supply_over_in} = 4'h0;
      {line_above_high_in, line_below_low_in, chip_hot_in, ext_hot_in} = 4'h0;
      fb_above_start_in = 1'b1;
      timer_tick_in = 1'b1;
      on_len = 8'h1E;
      demag_len = 8'h0A;
      repeat (20) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      step(2);
      check(temp_bias_en_out, 1'b1);
      t_comp();
      t_switch();
      t_blank();
      t_hard();
      t_olp();
      t_auxov();
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
